/* verilog/spm_monitor.sv */
// What this block does
// R1 - Select mode: frame starts when select turns active, ends when it turns inactive.
// R2 - Idle mode: frame closes after clock idles the minimum time; next edge starts one.
// R3 - Idle framing never looks at the select line.
// R4 - A frame is successive words; a valid frame holds at least one whole word.
// R5 - Start-of-frame trigger fires as a new frame begins.
// R6 - End-of-frame trigger fires as the current frame ends.
// R7 - Main-out pattern trigger, only when a main-out line is assigned.
// R8 - Main-in pattern trigger, only when a main-in line is assigned.
// R9 - Bit search compares the pattern at every bit position of the frame.
// R10 - Word search compares the pattern only at word starts.
// R11 - Data trigger uses a selectable operator such as equal or greater.
// R12 - Skip a programmed count of bits or words before comparing.
// R13 - Frames tagged void, length error or incomplete; each class filter-selectable.
// R14 - Frames classed main-out, main-in or both; all enabled classes pass together.
// R15 - Field condition compares data with one or two patterns by operator.
// R16 - Index condition compares word index with one or two limits; default 1 to 65535.
// R17 - Clean frames pass on enabled type and field conditions; error frames pass on their error-class enable.
// R18 - Invert toggles every frame-type and error-class enable.
// R19 - Word length is configurable up to 32 bits.
// R20 - Select and each data line have their own active level.
// R21 - Words assemble most or least significant bit first.
// R22 - Polarity and phase choose the sampling edge; observed pair shares them.
// R23 - All pins are synchronised before edge detection; reset clears frame state.
`timescale 1ns/100ps
`default_nettype none
`include "spm_params.svh"

module spm_monitor
   import spm_pkg::*;
#(
   parameter int WORD_MAX = `SPM_WORD_MAX,
   parameter int CNT_W    = `SPM_CNT_W,
   parameter int IDLE_W   = `SPM_IDLE_W
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   // Observed bus pins
   input  wire logic                sclk_in,
   input  wire logic                cs_in,
   input  wire logic                mosi_in,
   input  wire logic                miso_in,
   // Line setup
   input  wire logic                mosi_present_in,
   input  wire logic                miso_present_in,
   input  wire logic                cs_act_high_in,
   input  wire logic                mosi_act_high_in,
   input  wire logic                miso_act_high_in,
   input  wire logic                cpol_in,
   input  wire logic                cpha_in,
   input  wire logic                lsb_first_in,
   input  wire logic [5:0]          word_len_in,
   // Framing
   input  wire logic                frame_by_idle_in,
   input  wire logic [IDLE_W-1:0]   idle_cycles_in,
   // Trigger setup
   input  wire logic [1:0]          trig_type_in,
   input  wire logic                trig_word_aligned_in,
   input  wire logic [2:0]          trig_op_in,
   input  wire logic [WORD_MAX-1:0] trig_lo_in,
   input  wire logic [WORD_MAX-1:0] trig_hi_in,
   input  wire logic [CNT_W-1:0]    trig_skip_in,
   // Filter commands and setup
   input  wire logic                filt_load_in,
   input  wire logic                filt_reset_in,
   input  wire logic                filt_invert_in,
   input  wire logic [2:0]          type_en_in,
   input  wire logic [2:0]          err_en_in,
   input  wire logic [CNT_W-1:0]    idx_lo_in,
   input  wire logic [CNT_W-1:0]    idx_hi_in,
   input  wire logic [1:0]          field_en_in,
   input  wire logic [2:0]          fld_op_in,
   input  wire logic [WORD_MAX-1:0] fld_lo_in,
   input  wire logic [WORD_MAX-1:0] fld_hi_in,
   input  wire logic [2:0]          idx_op_in,
   // Events
   output logic                     trigger_out,
   output logic                     frame_start_out,
   output logic                     frame_end_out,
   // Assembled words
   output logic                     word_valid_out,
   output logic [WORD_MAX-1:0]      mosi_word_out,
   output logic [WORD_MAX-1:0]      miso_word_out,
   output logic [CNT_W-1:0]         word_index_out,
   // Frame result
   output logic                     frame_done_out,
   output logic                     frame_pass_out,
   output logic [2:0]               frame_err_out,
   output logic [2:0]               frame_class_out,
   output logic [CNT_W-1:0]         frame_words_out,
   // Filter enable state
   output logic [2:0]               type_en_out,
   output logic [2:0]               err_en_out,
   output logic [CNT_W-1:0]         idx_lo_out,
   output logic [CNT_W-1:0]         idx_hi_out
);

   localparam logic [5:0] WL_MAX = 6'(WORD_MAX);

   logic [3:0]          pins_s;
   logic                sclk_d;
   logic                in_frame;
   logic [1:0]          warm;
   logic [IDLE_W-1:0]   idle_cnt;
   logic [5:0]          bit_cnt;
   logic [CNT_W-1:0]    tot_bits;
   logic [CNT_W-1:0]    words;
   logic [WORD_MAX-1:0] acc_m;
   logic [WORD_MAX-1:0] acc_s;
   logic [WORD_MAX-1:0] win_m;
   logic [WORD_MAX-1:0] win_s;
   logic                fhit_m;
   logic                fhit_s;
   logic                trg_match;
   logic                fm_match;
   logic                fs_match;
   logic                idx_match;

   spm_sync #(
      .W (4)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     ({sclk_in, cs_in, mosi_in, miso_in}),
      .q_out    (pins_s)
   ); // see R23

   // Line levels after the active-level setting
   wire sclk_s = pins_s[3];
   wire cs_act = pins_s[2] ~^ cs_act_high_in;   // see R20
   wire mosi_b = pins_s[1] ~^ mosi_act_high_in; // see R20
   wire miso_b = pins_s[0] ~^ miso_act_high_in; // see R20

   // Clock edges; rising edge samples when polarity equals phase
   wire rise      = sclk_s & ~sclk_d;
   wire fall      = ~sclk_s & sclk_d;
   wire any_edge  = rise | fall;
   wire samp_edge = (cpol_in ~^ cpha_in) ? rise : fall; // see R22

   // Word length clamped to 1..WORD_MAX
   wire [5:0] wl = (word_len_in == 6'h00) ? 6'h01 :
                   (word_len_in > WL_MAX) ? WL_MAX : word_len_in; // see R19
   wire [5:0] wl_m1 = wl - 6'h01;
   wire [5:0] sh_amt = WL_MAX - wl;
   wire [WORD_MAX-1:0] wmask = {WORD_MAX{1'b1}} >> sh_amt;

   // Frame delimiting; the idle path never reads the select line
   wire idle_hit = idle_cnt >= idle_cycles_in;
   wire start_ev = &warm & ~in_frame & (frame_by_idle_in ? any_edge : cs_act);                   // see R1, R2, R3, R23
   wire end_ev   = frame_by_idle_in ? (in_frame & ~any_edge & idle_hit) : (in_frame & ~cs_act); // see R1, R2, R3
   wire take     = samp_edge & (in_frame | start_ev) & ~end_ev;

   // Counters restart on the cycle a frame starts, so a bit on that edge is kept
   wire [5:0]          b_bit   = start_ev ? 6'h00 : bit_cnt;
   wire [CNT_W-1:0]    b_tot   = start_ev ? '0 : tot_bits;
   wire [CNT_W-1:0]    b_words = start_ev ? '0 : words;
   wire [WORD_MAX-1:0] b_acc_m = start_ev ? '0 : acc_m;
   wire [WORD_MAX-1:0] b_acc_s = start_ev ? '0 : acc_s;
   wire [WORD_MAX-1:0] b_win_m = start_ev ? '0 : win_m;
   wire [WORD_MAX-1:0] b_win_s = start_ev ? '0 : win_s;
   wire                b_fh_m  = start_ev ? 1'b0 : fhit_m;
   wire                b_fh_s  = start_ev ? 1'b0 : fhit_s;

   wire word_done = take & (b_bit == wl_m1); // see R4

   wire [WORD_MAX-1:0] one_m = {{(WORD_MAX-1){1'b0}}, mosi_b};
   wire [WORD_MAX-1:0] one_s = {{(WORD_MAX-1){1'b0}}, miso_b};

   // Word assembly in either bit order
   wire [WORD_MAX-1:0] next_acc_m = lsb_first_in ? (b_acc_m | (one_m << b_bit))
                                                 : {b_acc_m[WORD_MAX-2:0], mosi_b}; // see R21
   wire [WORD_MAX-1:0] next_acc_s = lsb_first_in ? (b_acc_s | (one_s << b_bit))
                                                 : {b_acc_s[WORD_MAX-2:0], miso_b}; // see R21

   // Sliding window of the last wl bits for the bit-granular search
   wire [WORD_MAX-1:0] next_win_m = lsb_first_in ? {mosi_b, b_win_m[WORD_MAX-1:1]}
                                                 : {b_win_m[WORD_MAX-2:0], mosi_b};
   wire [WORD_MAX-1:0] next_win_s = lsb_first_in ? {miso_b, b_win_s[WORD_MAX-1:1]}
                                                 : {b_win_s[WORD_MAX-2:0], miso_b};
   wire [WORD_MAX-1:0] wv_m = lsb_first_in ? (next_win_m >> sh_amt) : (next_win_m & wmask);
   wire [WORD_MAX-1:0] wv_s = lsb_first_in ? (next_win_s >> sh_amt) : (next_win_s & wmask);

   wire [5:0]       next_bit   = word_done ? 6'h00 : b_bit + 6'h01;
   wire [CNT_W-1:0] next_tot   = (&b_tot) ? b_tot : b_tot + CNT_W'(1);
   wire [CNT_W-1:0] next_words = (word_done && !(&b_words)) ? b_words + CNT_W'(1) : b_words;
   wire [CNT_W-1:0] word_idx   = b_words + CNT_W'(1);

   // Trigger data selection and position check
   wire trg_on_miso = (trig_type_in == SPM_TRG_MISO);
   wire trg_data    = ((trig_type_in == SPM_TRG_MOSI) & mosi_present_in) |
                      (trg_on_miso & miso_present_in); // see R7, R8
   wire [WORD_MAX-1:0] word_sel = trg_on_miso ? next_acc_s : next_acc_m;
   wire [WORD_MAX-1:0] win_sel  = trg_on_miso ? wv_s : wv_m;
   wire [WORD_MAX-1:0] trg_val  = trig_word_aligned_in ? word_sel : win_sel; // see R9, R10
   wire [CNT_W:0]      need     = (CNT_W+1)'(trig_skip_in) + (CNT_W+1)'(wl);
   wire bit_pos_ok  = {1'b0, next_tot} >= need;                        // see R9, R12
   wire word_pos_ok = word_done & (b_words >= trig_skip_in);           // see R10, R12
   wire pos_ok      = trig_word_aligned_in ? word_pos_ok : bit_pos_ok;
   wire data_hit    = take & trg_data & pos_ok & trg_match;            // see R11
   wire trig_fire   = ((trig_type_in == SPM_TRG_SOF) & start_ev) |     // see R5
                      ((trig_type_in == SPM_TRG_EOF) & end_ev) |       // see R6
                      data_hit;

   spm_cmp #(
      .W (WORD_MAX)
   ) u_trg_cmp (
      .op_in     (trig_op_in),
      .val_in    (trg_val),
      .lo_in     (trig_lo_in),
      .hi_in     (trig_hi_in),
      .match_out (trg_match)
   ); // see R11

   // Field conditions: a word whose index and value both match sets the hit
   spm_cmp #(
      .W (WORD_MAX)
   ) u_fm_cmp (
      .op_in     (fld_op_in),
      .val_in    (next_acc_m),
      .lo_in     (fld_lo_in),
      .hi_in     (fld_hi_in),
      .match_out (fm_match)
   ); // see R15

   spm_cmp #(
      .W (WORD_MAX)
   ) u_fs_cmp (
      .op_in     (fld_op_in),
      .val_in    (next_acc_s),
      .lo_in     (fld_lo_in),
      .hi_in     (fld_hi_in),
      .match_out (fs_match)
   ); // see R15

   spm_cmp #(
      .W (CNT_W)
   ) u_idx_cmp (
      .op_in     (idx_op_in),
      .val_in    (word_idx),
      .lo_in     (idx_lo_out),
      .hi_in     (idx_hi_out),
      .match_out (idx_match)
   ); // see R16

   wire next_fh_m = b_fh_m | (word_done & mosi_present_in & idx_match & fm_match); // see R15, R16
   wire next_fh_s = b_fh_s | (word_done & miso_present_in & idx_match & fs_match); // see R15, R16

   // Frame classification from the assigned data lines
   wire [2:0] cls;
   assign cls[`SPM_CLS_MOSI] = mosi_present_in & ~miso_present_in;
   assign cls[`SPM_CLS_MISO] = miso_present_in & ~mosi_present_in;
   assign cls[`SPM_CLS_BOTH] = mosi_present_in & miso_present_in; // see R14

   // Error classes judged on the state before the closing cycle
   wire partial = bit_cnt != 6'h00;
   wire no_word = words == '0;
   wire [2:0] err;
   assign err[`SPM_ERR_VOID] = no_word & ~partial;
   assign err[`SPM_ERR_INC]  = no_word & partial;
   assign err[`SPM_ERR_LEN]  = ~no_word & partial; // see R13, R4

   // Error frames pass on their class enable; clean frames on type and fields
   wire fld_ok = (~field_en_in[0] | fhit_m) & (~field_en_in[1] | fhit_s);
   wire pass   = (|err) ? |(err & err_en_out)
                        : (|(cls & type_en_out) & fld_ok); // see R13, R14, R17

   // Framing state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_d   <= 1'b0;
         in_frame <= 1'b0;
         idle_cnt <= '0;
         warm     <= 2'h0;
      end else begin
         sclk_d   <= sclk_s;
         warm     <= warm + {1'b0, ~&warm}; // see R23
         in_frame <= start_ev | (in_frame & ~end_ev);
         if (any_edge || !in_frame)
            idle_cnt <= '0;
         else if (!idle_hit)
            idle_cnt <= idle_cnt + IDLE_W'(1); // see R2
      end
   end

   // Bit and word collection, cleared at reset and at every frame start
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bit_cnt  <= 6'h00;
         tot_bits <= '0;
         words    <= '0;
         acc_m    <= '0;
         acc_s    <= '0;
         win_m    <= '0;
         win_s    <= '0;
         fhit_m   <= 1'b0;
         fhit_s   <= 1'b0;
      end else if (take) begin
         bit_cnt  <= next_bit;
         tot_bits <= next_tot;
         words    <= next_words;
         acc_m    <= word_done ? '0 : next_acc_m;
         acc_s    <= word_done ? '0 : next_acc_s;
         win_m    <= next_win_m;
         win_s    <= next_win_s;
         fhit_m   <= next_fh_m;
         fhit_s   <= next_fh_s;
      end else if (start_ev) begin
         bit_cnt  <= 6'h00;
         tot_bits <= '0;
         words    <= '0;
         acc_m    <= '0;
         acc_s    <= '0;
         win_m    <= '0;
         win_s    <= '0;
         fhit_m   <= 1'b0;
         fhit_s   <= 1'b0;
      end
   end

   // Filter enables; reset beats load, load beats invert
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         type_en_out <= `SPM_TYPE_EN_RST;
         err_en_out  <= `SPM_ERR_EN_RST;
         idx_lo_out  <= `SPM_IDX_LO_RST;
         idx_hi_out  <= `SPM_IDX_HI_RST;
      end else if (filt_reset_in) begin
         type_en_out <= `SPM_TYPE_EN_RST;
         err_en_out  <= `SPM_ERR_EN_RST;
         idx_lo_out  <= `SPM_IDX_LO_RST; // see R16
         idx_hi_out  <= `SPM_IDX_HI_RST; // see R16
      end else if (filt_load_in) begin
         type_en_out <= type_en_in;
         err_en_out  <= err_en_in;
         idx_lo_out  <= idx_lo_in;
         idx_hi_out  <= idx_hi_in;
      end else if (filt_invert_in) begin
         type_en_out <= ~type_en_out; // see R18
         err_en_out  <= ~err_en_out;  // see R18
      end
   end

   // Event and word outputs
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trigger_out     <= 1'b0;
         frame_start_out <= 1'b0;
         frame_end_out   <= 1'b0;
         word_valid_out  <= 1'b0;
         mosi_word_out   <= '0;
         miso_word_out   <= '0;
         word_index_out  <= '0;
      end else begin
         trigger_out     <= trig_fire;
         frame_start_out <= start_ev;
         frame_end_out   <= end_ev;
         word_valid_out  <= word_done;
         if (word_done) begin
            mosi_word_out  <= next_acc_m;
            miso_word_out  <= next_acc_s;
            word_index_out <= word_idx;
         end
      end
   end

   // Frame done pulse, and the frame result held until the next frame closes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_done_out  <= 1'b0;
         frame_pass_out  <= 1'b0;
         frame_err_out   <= 3'h0;
         frame_class_out <= 3'h0;
         frame_words_out <= '0;
      end else begin
         frame_done_out <= end_ev;
         if (end_ev) begin
            frame_pass_out  <= pass; // see R17
            frame_err_out   <= err;
            frame_class_out <= cls;
            frame_words_out <= words;
         end
      end
   end

endmodule

`default_nettype wire

/* verilog/spm_params.svh */
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

// Longest word the assembler holds, in bits
`define SPM_WORD_MAX      32
// Width of the bit and word counters inside a frame
`define SPM_CNT_W         16
// Width of the clock-idle counter, in sampling clock cycles
`define SPM_IDLE_W        24

// Index condition default range
`define SPM_IDX_LO_RST    16'h0001
`define SPM_IDX_HI_RST    16'hffff

// Frame-type enable positions and reset value
`define SPM_CLS_MOSI      0
`define SPM_CLS_MISO      1
`define SPM_CLS_BOTH      2
`define SPM_TYPE_EN_RST   3'h7

// Error-class enable positions and reset value
`define SPM_ERR_VOID      0
`define SPM_ERR_LEN       1
`define SPM_ERR_INC       2
`define SPM_ERR_EN_RST    3'h7

`endif

/* verilog/spm_pkg.sv */
package spm_pkg;

   typedef enum logic [2:0] {
      SPM_OP_EQ,
      SPM_OP_NE,
      SPM_OP_LT,
      SPM_OP_LE,
      SPM_OP_GT,
      SPM_OP_GE,
      SPM_OP_IN,
      SPM_OP_OUT
   } spm_op_e;

   typedef enum logic [1:0] {
      SPM_TRG_SOF,
      SPM_TRG_EOF,
      SPM_TRG_MOSI,
      SPM_TRG_MISO
   } spm_trig_e;

endpackage

/* verilog/spm_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module spm_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // Asynchronous inputs and their synchronised copies
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic meta;
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta     <= 1'b0;
               q_out[i] <= 1'b0;
            end else begin
               meta     <= d_in[i];
               q_out[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* verilog/spm_cmp.sv */
`timescale 1ns/100ps
`default_nettype none

module spm_cmp
   import spm_pkg::*;
#(
   parameter int W = 32
) (
   // Operator and operands
   input  wire logic [2:0]   op_in,
   input  wire logic [W-1:0] val_in,
   input  wire logic [W-1:0] lo_in,
   input  wire logic [W-1:0] hi_in,
   // Result
   output logic              match_out
);

   spm_op_e op;
   wire     in_rng;

   assign op     = spm_op_e'(op_in);
   assign in_rng = (val_in >= lo_in) && (val_in <= hi_in);

   // Single-value operators use lo only; range operators use both limits
   assign match_out = (op == SPM_OP_EQ)  ? (val_in == lo_in) :
                      (op == SPM_OP_NE)  ? (val_in != lo_in) :
                      (op == SPM_OP_LT)  ? (val_in <  lo_in) :
                      (op == SPM_OP_LE)  ? (val_in <= lo_in) :
                      (op == SPM_OP_GT)  ? (val_in >  lo_in) :
                      (op == SPM_OP_GE)  ? (val_in >= lo_in) :
                      (op == SPM_OP_IN)  ? in_rng :
                                           !in_rng;

endmodule

`default_nettype wire

/* sim/spm_monitor_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module spm_monitor_checker
   import spm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Watched inputs
   input  wire logic       cs_in,
   input  wire logic       cs_act_high_in,
   input  wire logic       frame_by_idle_in,
   input  wire logic [1:0] trig_type_in,
   input  wire logic       filt_load_in,
   input  wire logic       filt_reset_in,
   input  wire logic       filt_invert_in,
   input  wire logic [2:0] type_en_in,
   input  wire logic [2:0] err_en_in,
   // Watched outputs
   input  wire logic       trigger_out,
   input  wire logic       frame_start_out,
   input  wire logic       frame_end_out,
   input  wire logic       frame_done_out,
   input  wire logic [2:0] type_en_out,
   input  wire logic [2:0] err_en_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic cs_act = (cs_in == cs_act_high_in);

   a_select_starts: assert property ($rose(cs_act) && !frame_by_idle_in |-> ##3 frame_start_out)
      else $error("frame start not 3 cycles after select");
   a_select_ends: assert property ($fell(cs_act) && !frame_by_idle_in |-> ##3 frame_end_out)
      else $error("frame end not 3 cycles after deselect");
   a_end_done_pair: assert property (frame_end_out |-> frame_done_out)
      else $error("frame end without frame result");
   a_sof_trigger: assert property (frame_start_out && trig_type_in == SPM_TRG_SOF |-> trigger_out)
      else $error("no trigger at frame start");
   a_eof_trigger: assert property (frame_end_out && trig_type_in == SPM_TRG_EOF |-> trigger_out)
      else $error("no trigger at frame end");
   a_filt_reset: assert property (filt_reset_in |=> type_en_out == 3'h7 && err_en_out == 3'h7)
      else $error("filter reset left enables");
   a_filt_load: assert property (filt_load_in && !filt_reset_in |=>
      type_en_out == $past(type_en_in) && err_en_out == $past(err_en_in))
      else $error("filter load wrong");
   a_filt_invert: assert property (filt_invert_in && !filt_load_in && !filt_reset_in |=>
      type_en_out == ~$past(type_en_out) && err_en_out == ~$past(err_en_out))
      else $error("filter invert wrong");
endmodule

bind spm_monitor spm_monitor_checker chk_u (.clk_in, .rst_n_in, .cs_in, .cs_act_high_in, .frame_by_idle_in,
   .trig_type_in, .filt_load_in, .filt_reset_in, .filt_invert_in, .type_en_in, .err_en_in, .trigger_out,
   .frame_start_out, .frame_end_out, .frame_done_out, .type_en_out, .err_en_out);
`default_nettype wire

/* sim/spm_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spm_bus_model (
   // Observed pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out,
   output logic miso_out
);
   initial begin
      sclk_out = 1'h0;
      cs_n_out = 1'h1;
      mosi_out = 1'h0;
      miso_out = 1'h1;
   end
   // Offset keeps pin edges off clock edges
   task automatic xfer(input logic [31:0] mo, input logic [31:0] mi, input int n, input bit sel);
      #7;
      cs_n_out = !sel;
      #160;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_out = mo[i];
         miso_out = mi[i];
         #160 sclk_out = 1'h1;
         #160 sclk_out = 1'h0;
      end
      // Released lines show the inverse
      mosi_out = !mosi_out;
      miso_out = !miso_out;
      #160 cs_n_out = 1'h1;
      #2000;
   endtask
endmodule
`default_nettype wire

/* sim/tb_spm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_spm_monitor
   import spm_pkg::*;
();
   typedef struct {
      spm_trig_e   ty;
      logic        al;
      spm_op_e     op;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [15:0] sk;
      logic [1:0]  mp;
      int          ex;
   } spm_tcase_s;
   spm_tcase_s tc [11] = '{
      '{SPM_TRG_SOF, 1'h1, SPM_OP_EQ, 32'h0, 32'h0, 16'h0, 2'h3, 1},
      '{SPM_TRG_EOF, 1'h1, SPM_OP_EQ, 32'h0, 32'h0, 16'h0, 2'h3, 1},
      '{SPM_TRG_MOSI, 1'h1, SPM_OP_EQ, 32'h3c, 32'h0, 16'h1, 2'h3, 1},
      '{SPM_TRG_MOSI, 1'h1, SPM_OP_EQ, 32'ha5, 32'h0, 16'h1, 2'h3, 0},
      '{SPM_TRG_MOSI, 1'h1, SPM_OP_GT, 32'h40, 32'h0, 16'h0, 2'h3, 1},
      '{SPM_TRG_MOSI, 1'h1, SPM_OP_IN, 32'h30, 32'h40, 16'h0, 2'h3, 1},
      '{SPM_TRG_MOSI, 1'h0, SPM_OP_EQ, 32'h53, 32'h0, 16'h4, 2'h3, 1},
      '{SPM_TRG_MOSI, 1'h0, SPM_OP_EQ, 32'h53, 32'h0, 16'h5, 2'h3, 0},
      '{SPM_TRG_MOSI, 1'h1, SPM_OP_EQ, 32'ha5, 32'h0, 16'h0, 2'h2, 0},
      '{SPM_TRG_MISO, 1'h1, SPM_OP_EQ, 32'h0f, 32'h0, 16'h0, 2'h3, 1},
      '{SPM_TRG_MISO, 1'h1, SPM_OP_EQ, 32'h0f, 32'h0, 16'h0, 2'h1, 0}};
   int          en [5] = '{12, 3, 0, 16, 3};
   logic [2:0]  ee [5] = '{3'h2, 3'h4, 3'h1, 3'h0, 3'h4};
   logic [1:0]  ew [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
   logic        ep [5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
   logic        clk_in = 1'h0;
   logic        rst_n_in = 1'h0;
   wire logic   sclk, cs_n, mosi, miso;
   logic        lsb = 1'h0, idl = 1'h0, al = 1'h1, fl = 1'h0, fr = 1'h0, fi = 1'h0;
   logic [1:0]  ty = 2'h0, fen = 2'h0, mp = 2'h3;
   logic [2:0]  op = 3'h0, ten = 3'h7, een = 3'h7, fop = 3'h0, iop = 3'h6;
   logic [5:0]  wl = 6'h08;
   logic [23:0] idc = 24'h14;
   logic [31:0] lo = 32'h0, hi = 32'h0, flo = 32'h0, mw, sw;
   logic [15:0] sk = 16'h0, ilo_i = 16'h1, ihi_i = 16'hffff, widx, fw, ilo, ihi;
   logic        trig, fd, fp, wv;
   logic [2:0]  ferr, fcls, teo, eeo;
   int          failures = 0, num_checks = 0, ntrig = 0, ndone = 0, cyc = 0, nwv = 0;

   spm_bus_model bus_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_out(miso));
   spm_monitor dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_in(cs_n), .mosi_in(mosi), .miso_in(miso),
      .mosi_present_in(mp[0]), .miso_present_in(mp[1]), .cs_act_high_in(1'h0), .mosi_act_high_in(1'h1),
      .miso_act_high_in(1'h1), .cpol_in(1'h0), .cpha_in(1'h0), .lsb_first_in(lsb), .word_len_in(wl),
      .frame_by_idle_in(idl), .idle_cycles_in(idc), .trig_type_in(ty), .trig_word_aligned_in(al),
      .trig_op_in(op), .trig_lo_in(lo), .trig_hi_in(hi), .trig_skip_in(sk), .filt_load_in(fl),
      .filt_reset_in(fr), .filt_invert_in(fi), .type_en_in(ten), .err_en_in(een), .idx_lo_in(ilo_i),
      .idx_hi_in(ihi_i), .field_en_in(fen), .fld_op_in(fop), .fld_lo_in(flo), .fld_hi_in(hi),
      .idx_op_in(iop), .trigger_out(trig), .frame_start_out(), .frame_end_out(), .word_valid_out(wv),
      .mosi_word_out(mw), .miso_word_out(sw), .word_index_out(widx), .frame_done_out(fd),
      .frame_pass_out(fp), .frame_err_out(ferr), .frame_class_out(fcls), .frame_words_out(fw),
      .type_en_out(teo), .err_en_out(eeo), .idx_lo_out(ilo), .idx_hi_out(ihi));

   always #20 clk_in = ~clk_in;

   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cmd(input int k);
      @(posedge clk_in);
      fr <= (k == 0);
      fl <= (k == 1);
      fi <= (k == 2);
      @(posedge clk_in);
      fr <= 1'h0;
      fl <= 1'h0;
      fi <= 1'h0;
      @(negedge clk_in);
   endtask

   task automatic frame(input logic [31:0] mo, input int n, input bit sel);
      @(negedge clk_in);
      ntrig = 0;
      ndone = 0;
      nwv = 0;
      bus_u.xfer(mo, 32'h5a0f, n, sel);
      check("frames done", ndone, 1);
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (trig === 1'h1) ntrig <= ntrig + 1;
      if (fd === 1'h1) ndone <= ndone + 1;
      if (wv === 1'h1) nwv <= nwv + 1;
      if (cyc == 12000) begin
         failures = failures + 1;
         close_out();
      end
   end

   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (2) @(negedge clk_in);
      check("reset state", {teo, eeo, ilo, ihi}, {3'h7, 3'h7, 16'h1, 16'hffff});
      @(posedge clk_in);
      ten <= 3'h5;
      een <= 3'h2;
      ilo_i <= 16'h2;
      cmd(1);
      check("load", {teo, eeo, ilo}, {3'h5, 3'h2, 16'h2});
      cmd(2);
      check("invert", {teo, eeo}, {3'h2, 3'h5});
      cmd(0);
      check("filter reset", {teo, eeo, ilo, ihi}, {3'h7, 3'h7, 16'h1, 16'hffff});
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_in);
         ty <= tc[i].ty;
         al <= tc[i].al;
         op <= tc[i].op;
         lo <= tc[i].lo;
         hi <= tc[i].hi;
         sk <= tc[i].sk;
         mp <= tc[i].mp;
         frame(32'ha53c, 16, 1'h1);
         check("triggers", ntrig, tc[i].ex);
         if (i == 0) check("both lines", {sw, fcls}, {32'hf, 3'h4});
      end
      check("words", {mw, widx, fw}, {32'h3c, 16'h2, 16'h2});
      check("word pulses", nwv, 2);
      check("result", {ferr, fcls, fp}, {3'h0, 3'h1, 1'h1});
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in);
         ty <= SPM_TRG_SOF;
         mp <= 2'h3;
         if (i == 3) cmd(2);
         frame(32'ha53c, en[i], 1'h1);
         check("frame result", {ferr, fw, fp}, {ee[i], 14'h0, ew[i], ep[i]});
      end
      cmd(0);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_in);
         fen <= 2'h1;
         flo <= i ? 32'h77 : 32'h3c;
         frame(32'ha53c, 16, 1'h1);
         check("field pass", fp, i ? 1'h0 : 1'h1);
      end
      @(posedge clk_in);
      fen <= 2'h0;
      lsb <= 1'h1;
      frame(32'h35, 8, 1'h1);
      check("lsb word", mw, 32'hac);
      @(posedge clk_in);
      lsb <= 1'h0;
      idl <= 1'h1;
      wl <= 6'h0c;
      frame(32'h5a3, 12, 1'h0);
      check("idle frame", {mw, fw, ferr}, {32'h5a3, 16'h1, 3'h0});
      close_out();
   end
endmodule
`default_nettype wire
